//--- qsp_top.sv
// Two-channel queued serial port with AXI4-Lite register access
//
// Function
// - Receive bits enter shifter LSB first
// - Complete character moves to receive queue automatically
// - Receive queue holds 64 eight-bit characters
// - Reading empty receive queue gives undefined value
// - Characters arriving at full queue are dropped
// - Receive queue port is read-only
// - Transmit shifter sends queued character LSB first
// - Next queued character loads automatically after one
// - Write to idle transmitter starts transmission
// - Transmit queue 64 bytes, write-only
// - Writes to full transmit queue are ignored
// - Shifters are not reachable by software
// - Mode register top five bits read zero
// - Sampling field selects async oversampling ratio
// - Prohibited sampling codes; field async only
// - Bit 7 selects async or synchronous mode
// - Bit 6 selects 8 or 7 bits, async
// - Synchronous mode always uses eight bits
// - Seven-bit frames omit transmit bit 7
// - Parity enable bit 5, async only
// - Bit 4 selects even or odd parity
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns

module qsp_top #(
  parameter int NCH      = qsp_pkg::QSP_CHANNELS,
  parameter int DEPTH    = qsp_pkg::QSP_FIFO_DEPTH,
  parameter int TICK_DIV = qsp_pkg::QSP_TICK_DIV
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [qsp_pkg::QSP_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [qsp_pkg::QSP_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic [NCH-1:0]                  rxd,
  output logic      [NCH-1:0]                  txd,
  output logic      [NCH-1:0]                  sck
);
  import qsp_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [TW-1:0] TICK_TOP = TW'(TICK_DIV - 1);

  // ***********************************************
  // Helper functions
  // ***********************************************
  function automatic logic addr_ok(input logic [QSP_AXI_AW-1:0] a);
    addr_ok = (a[QSP_AXI_AW-1:QSP_CH_LSB] < NCH)
              && (a[QSP_CH_LSB-1:QSP_REG_LSB] <= QSP_IDX_LAST);
  endfunction : addr_ok

  // Bit period in sample ticks; prohibited codes fall back to 1/16
  function automatic logic [4:0] ratio(input logic [15:0] m);
    if (m[QSP_SYNC_BIT]) begin
      ratio = QSP_RATIO_SYNC;
    end else begin
      unique case (m[QSP_SRC_LSB+:3])
        3'h0:    ratio = 5'h10;
        3'h1:    ratio = 5'h05;
        3'h2:    ratio = 5'h0B;
        3'h3:    ratio = 5'h0D;
        3'h4:    ratio = 5'h1D;
        default: ratio = 5'h10;
      endcase
    end
  endfunction : ratio

  function automatic logic [2:0] last_bit(input logic [15:0] m);
    last_bit = (!m[QSP_SYNC_BIT] && m[QSP_CHR_BIT]) ? 3'h6 : 3'h7;
  endfunction : last_bit

  function automatic logic par_on(input logic [15:0] m);
    par_on = !m[QSP_SYNC_BIT] && m[QSP_PE_BIT];
  endfunction : par_on

  // ***********************************************
  // AXI4-Lite slave
  // ***********************************************
  logic [QSP_AXI_AW-1:0] aw_addr_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  wr_fire;
  logic                  rd_fire;
  logic [NCH-1:0]        wr_sel;
  logic [NCH-1:0]        rd_sel;
  logic [2:0]            wr_idx;
  logic [2:0]            rd_idx;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx  = aw_addr_q[QSP_CH_LSB-1:QSP_REG_LSB];
  assign rd_idx  = s_axi_araddr[QSP_CH_LSB-1:QSP_REG_LSB];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wr_sel[c] = wr_fire && addr_ok(aw_addr_q)
                  && (aw_addr_q[QSP_AXI_AW-1:QSP_CH_LSB] == c);
      rd_sel[c] = rd_fire && addr_ok(s_axi_araddr)
                  && (s_axi_araddr[QSP_AXI_AW-1:QSP_CH_LSB] == c);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr_q     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_q     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data_q     <= '0;
      w_strb_q     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= QSP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(aw_addr_q) ? QSP_RESP_OKAY : QSP_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***********************************************
  // Per-channel state visible to the read mux
  // ***********************************************
  logic [15:0]   mode_q   [NCH];
  logic [7:0]    rx_head  [NCH];
  logic [CW-1:0] rx_cnt_q [NCH];
  logic [CW-1:0] tx_cnt_q [NCH];
  logic [NCH-1:0] perr_q;
  logic [NCH-1:0] ferr_q;
  logic [NCH-1:0] busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= QSP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? QSP_RESP_OKAY : QSP_RESP_DECERR;
      for (int c = 0; c < NCH; c++) begin
        if (rd_sel[c]) begin
          unique case (rd_idx)
            QSP_IDX_MODE: s_axi_rdata[15:0] <= mode_q[c] & QSP_MODE_WMASK;
            QSP_IDX_RXQ:  s_axi_rdata[7:0]  <= rx_head[c];
            QSP_IDX_STAT: begin
              s_axi_rdata[QSP_ST_RXCNT_LSB+:CW] <= rx_cnt_q[c];
              s_axi_rdata[QSP_ST_TXCNT_LSB+:CW] <= tx_cnt_q[c];
              s_axi_rdata[QSP_ST_PERR_BIT]      <= perr_q[c];
              s_axi_rdata[QSP_ST_FERR_BIT]      <= ferr_q[c];
              s_axi_rdata[QSP_ST_BUSY_BIT]      <= busy[c];
            end
            default: s_axi_rdata <= '0;
          endcase
        end
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ***********************************************
  // Sample tick shared by both channels
  // ***********************************************
  logic [TW-1:0] div_q;
  logic          tick;

  assign tick = (div_q == TICK_TOP);

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ***********************************************
  // Channels
  // ***********************************************
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [7:0]    rx_mem [DEPTH];
    logic [7:0]    tx_mem [DEPTH];
    logic [PW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic          rx_push, rx_pop, tx_push, tx_pop;
    logic [7:0]    rx_sh_q, tx_sh_q;
    logic [4:0]    rx_tk_q, tx_tk_q;
    logic [2:0]    rx_bit_q, tx_bit_q;
    logic          rx_par_q, tx_par_q, sck_prev_q;
    qsp_state_t    rx_st_q, tx_st_q;
    logic [4:0]    rat;
    logic          sync, tx_end, rx_mid, rx_end, sck_rise, perr_set, ferr_set;
    logic          st_clr;

    assign sync     = mode_q[ch][QSP_SYNC_BIT];
    assign rat      = ratio(mode_q[ch]);
    assign tx_end   = tick && (tx_tk_q == rat - 5'h01);
    assign rx_mid   = tick && (rx_tk_q == (rat >> 1) - 5'h01);
    assign rx_end   = tick && (rx_tk_q == rat - 5'h01);
    assign sck_rise = sck[ch] && !sck_prev_q;
    assign rx_head[ch] = rx_mem[rx_rp_q];
    assign busy[ch]    = (tx_st_q != QSP_S_IDLE);
    assign rx_pop   = rd_sel[ch] && (rd_idx == QSP_IDX_RXQ)
                      && (rx_cnt_q[ch] != '0);
    assign tx_push  = wr_sel[ch] && (wr_idx == QSP_IDX_TXQ) && w_strb_q[0]
                      && (tx_cnt_q[ch] != FULL_CNT);
    assign tx_pop   = (tx_st_q == QSP_S_IDLE) && (tx_cnt_q[ch] != '0);
    assign st_clr   = wr_sel[ch] && (wr_idx == QSP_IDX_STAT) && w_strb_q[2];

    // Mode register; receive queue address takes no write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_q[ch] <= QSP_MODE_RESET;
      end else if (wr_sel[ch] && (wr_idx == QSP_IDX_MODE)) begin
        if (w_strb_q[0]) mode_q[ch][7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) mode_q[ch][15:8] <= w_data_q[15:8] & QSP_MODE_WMASK[15:8];
      end
    end

    // Queues; memories need no reset, pointers do
    always_ff @(posedge aclk) begin
      if (rx_push) rx_mem[rx_wp_q] <= sync ? {rxd[ch], rx_sh_q[7:1]} :
                                      (last_bit(mode_q[ch]) == 3'h6) ?
                                      {1'b0, rx_sh_q[7:1]} : rx_sh_q;
      if (tx_push) tx_mem[tx_wp_q] <= w_data_q[7:0];
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_wp_q <= '0;
        rx_rp_q <= '0;
        tx_wp_q <= '0;
        tx_rp_q <= '0;
        rx_cnt_q[ch] <= '0;
        tx_cnt_q[ch] <= '0;
      end else begin
        rx_wp_q <= rx_wp_q + PW'(rx_push);
        rx_rp_q <= rx_rp_q + PW'(rx_pop);
        tx_wp_q <= tx_wp_q + PW'(tx_push);
        tx_rp_q <= tx_rp_q + PW'(tx_pop);
        rx_cnt_q[ch] <= rx_cnt_q[ch] + CW'(rx_push) - CW'(rx_pop);
        tx_cnt_q[ch] <= tx_cnt_q[ch] + CW'(tx_push) - CW'(tx_pop);
      end
    end

    // Transmitter
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tx_st_q  <= QSP_S_IDLE;
        tx_sh_q  <= '0;
        tx_tk_q  <= '0;
        tx_bit_q <= '0;
        tx_par_q <= 1'b0;
        txd[ch]  <= 1'b1;
      end else begin
        tx_tk_q <= tick ? (tx_end ? 5'h00 : tx_tk_q + 5'h01) : tx_tk_q;
        unique case (tx_st_q)
          QSP_S_IDLE: begin
            txd[ch] <= 1'b1;
            tx_tk_q <= '0;
            if (tx_pop) begin
              tx_sh_q  <= tx_mem[tx_rp_q];
              tx_bit_q <= '0;
              tx_par_q <= mode_q[ch][QSP_ODD_BIT];
              tx_st_q  <= sync ? QSP_S_DATA : QSP_S_START;
              txd[ch]  <= sync ? tx_mem[tx_rp_q][0] : 1'b0;
            end
          end
          QSP_S_START: if (tx_end) begin
            tx_st_q <= QSP_S_DATA;
            txd[ch] <= tx_sh_q[0];
          end
          QSP_S_DATA: if (tx_end) begin
            tx_sh_q  <= tx_sh_q >> 1;
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == last_bit(mode_q[ch])) begin
              tx_st_q <= sync ? QSP_S_IDLE :
                         (par_on(mode_q[ch]) ? QSP_S_PAR : QSP_S_STOP);
              txd[ch] <= sync ? 1'b1 :
                         (par_on(mode_q[ch]) ? tx_par_q ^ tx_sh_q[0] : 1'b1);
            end else begin
              txd[ch] <= tx_sh_q[1];
            end
          end
          QSP_S_PAR: if (tx_end) begin
            tx_st_q <= QSP_S_STOP;
            txd[ch] <= 1'b1;
          end
          QSP_S_STOP: if (tx_end) begin
            tx_st_q <= QSP_S_IDLE;
          end
          default: tx_st_q <= QSP_S_IDLE;
        endcase
      end
    end

    // Serial clock: low for the first half of each synchronous bit, idles high
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sck[ch]    <= 1'b1;
        sck_prev_q <= 1'b1;
      end else begin
        sck[ch]    <= !(sync && (tx_pop || (tx_st_q == QSP_S_DATA)
                        && (tx_end ? (tx_bit_q != last_bit(mode_q[ch]))
                                   : ((tx_tk_q == 5'h00) && !tick))));
        sck_prev_q <= sck[ch];
      end
    end

    // Receiver; synchronous mode only captures while this end drives the clock
    assign rx_push = (((rx_st_q == QSP_S_STOP) && rx_end)
                      || (sync && sck_rise && (rx_bit_q == 3'h7)))
                     && (rx_cnt_q[ch] != FULL_CNT);
    assign perr_set = (rx_st_q == QSP_S_PAR) && rx_end
                      && (rxd[ch] != (rx_par_q ^ mode_q[ch][QSP_ODD_BIT]));
    assign ferr_set = (rx_st_q == QSP_S_STOP) && rx_end && !rxd[ch];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_st_q  <= QSP_S_IDLE;
        rx_sh_q  <= '0;
        rx_tk_q  <= '0;
        rx_bit_q <= '0;
        rx_par_q <= 1'b0;
      end else begin
        rx_tk_q <= tick ? (rx_end || rx_mid && rx_st_q == QSP_S_START ? 5'h00 :
                           rx_tk_q + 5'h01) : rx_tk_q;
        unique case (rx_st_q)
          QSP_S_IDLE: begin
            rx_tk_q <= '0;
            if (sync) begin
              if (sck_rise) begin
                rx_sh_q  <= {rxd[ch], rx_sh_q[7:1]};
                rx_bit_q <= rx_bit_q + 3'h1;
              end
            end else if (tick && !rxd[ch]) begin
              rx_st_q  <= QSP_S_START;
              rx_bit_q <= '0;
              rx_par_q <= 1'b0;
            end
          end
          QSP_S_START: if (rx_mid) begin
            rx_st_q <= rxd[ch] ? QSP_S_IDLE : QSP_S_DATA;
          end
          QSP_S_DATA: if (rx_end) begin
            rx_sh_q  <= {rxd[ch], rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rxd[ch];
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit(mode_q[ch])) begin
              rx_st_q <= par_on(mode_q[ch]) ? QSP_S_PAR : QSP_S_STOP;
            end
          end
          QSP_S_PAR: if (rx_end) begin
            rx_st_q <= QSP_S_STOP;
          end
          QSP_S_STOP: if (rx_end) begin
            rx_st_q <= QSP_S_IDLE;
          end
          default: rx_st_q <= QSP_S_IDLE;
        endcase
      end
    end

    // Error flags: write one to clear, a new event wins over the clear
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        perr_q[ch] <= 1'b0;
        ferr_q[ch] <= 1'b0;
      end else begin
        perr_q[ch] <= perr_set || (perr_q[ch]
                      && !(st_clr && w_data_q[QSP_ST_PERR_BIT]));
        ferr_q[ch] <= ferr_set || (ferr_q[ch]
                      && !(st_clr && w_data_q[QSP_ST_FERR_BIT]));
      end
    end
  end

endmodule : qsp_top

//--- qsp_pkg.sv
// Shared constants and types of the queued serial port
package qsp_pkg;

  // ***********************************************
  // Register map, one block of registers per channel
  // ***********************************************
  localparam int          QSP_AXI_AW       = 8;
  localparam int          QSP_CH_LSB       = 5;
  localparam int          QSP_REG_LSB      = 2;
  localparam logic [2:0]  QSP_IDX_MODE     = 3'h0;
  localparam logic [2:0]  QSP_IDX_TXQ      = 3'h1;
  localparam logic [2:0]  QSP_IDX_RXQ      = 3'h2;
  localparam logic [2:0]  QSP_IDX_STAT     = 3'h3;
  localparam logic [2:0]  QSP_IDX_LAST     = 3'h3;
  localparam logic [1:0]  QSP_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  QSP_RESP_DECERR  = 2'h3;

  // ***********************************************
  // Mode register fields
  // ***********************************************
  localparam logic [15:0] QSP_MODE_RESET   = 16'h0000;
  localparam logic [15:0] QSP_MODE_WMASK   = 16'h07FF;
  localparam int          QSP_SRC_LSB      = 8;
  localparam int          QSP_SYNC_BIT     = 7;
  localparam int          QSP_CHR_BIT      = 6;
  localparam int          QSP_PE_BIT       = 5;
  localparam int          QSP_ODD_BIT      = 4;

  // ***********************************************
  // Status register fields
  // ***********************************************
  localparam int          QSP_ST_RXCNT_LSB = 0;
  localparam int          QSP_ST_TXCNT_LSB = 8;
  localparam int          QSP_ST_PERR_BIT  = 16;
  localparam int          QSP_ST_FERR_BIT  = 17;
  localparam int          QSP_ST_BUSY_BIT  = 18;

  // ***********************************************
  // Data path sizes and timing
  // ***********************************************
  localparam int          QSP_FIFO_DEPTH   = 64;
  localparam int          QSP_CHANNELS     = 2;
  localparam int          QSP_TICK_DIV     = 8;
  localparam logic [4:0]  QSP_RATIO_SYNC   = 5'h02;

  typedef enum logic [2:0] {
    QSP_S_IDLE  = 3'b000,
    QSP_S_START = 3'b001,
    QSP_S_DATA  = 3'b010,
    QSP_S_PAR   = 3'b011,
    QSP_S_STOP  = 3'b100
  } qsp_state_t;

endpackage : qsp_pkg

//--- qsp_top_props.sv
// Port assertions of the queued serial port
`timescale 1ns/1ns
module qsp_top_props
  import qsp_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [QSP_AXI_AW-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [QSP_AXI_AW-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [NCH-1:0]        rxd,
  input wire logic [NCH-1:0]        txd,
  input wire logic [NCH-1:0]        sck
);
  // ***********************************************
  // Captured addresses
  // ***********************************************
  logic [7:0] ar_q;
  logic [7:0] aw_q;
  always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  always_ff @(posedge aclk) if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ***********************************************
  // Properties
  // ***********************************************
  AST_MODE_TOP_ZERO: assert property (s_axi_rvalid && ar_q < 8'h40
    && ar_q[4:2] == QSP_IDX_MODE |-> s_axi_rdata[15:11] == 5'h00) else $error("mode top bits set");
  AST_TXQ_NO_READ: assert property (s_axi_rvalid && ar_q < 8'h40
    && ar_q[4:2] == QSP_IDX_TXQ |-> s_axi_rdata == 32'h0) else $error("tx queue readable");
  AST_RXQ_WR_OKAY: assert property (s_axi_bvalid && aw_q < 8'h40
    && aw_q[4:2] == QSP_IDX_RXQ |-> s_axi_bresp == QSP_RESP_OKAY) else $error("rx write resp");
  AST_IDLE_HIGH: assert property ($rose(aresetn) |-> txd == '1 && sck == '1)
    else $error("lines not idle after reset");
  AST_DECERR_RD: assert property (s_axi_rvalid && (ar_q >= 8'h40 || ar_q[4:2] > QSP_IDX_LAST)
    |-> s_axi_rresp == QSP_RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
endmodule : qsp_top_props

//--- qsp_uart_partner.sv
// Asynchronous serial device facing channel 0
`timescale 1ns/1ns
module qsp_uart_partner (
  input wire logic clk,
  input wire logic line_in,
  output logic     line_out
);
  int         bit_clks = 5;
  int         nbits    = 8;
  bit         par_en   = 1'b0;
  bit         odd      = 1'b0;
  logic [7:0] got_q[$];
  logic       par_q[$];
  initial line_out = 1'b1;

  // ***********************************************
  // Sender: start, data LSB first, parity, stop
  // ***********************************************
  task automatic put(input logic v);
    @(posedge clk);
    line_out <= v;
    repeat (bit_clks - 1) @(posedge clk);
  endtask : put

  task automatic send(input logic [7:0] b);
    logic [7:0] m;
    m = (nbits == 7) ? (b & 8'h7F) : b;
    put(1'b0);
    for (int i = 0; i < nbits; i++) put(m[i]);
    if (par_en) put(odd ^ (^m));
    put(1'b1);
  endtask : send

  // ***********************************************
  // Receiver, samples mid-bit
  // ***********************************************
  always begin : rx_proc
    logic [7:0] b;
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk);
    b = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk);
      b[i] = line_in;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge clk);
      par_q.push_back(line_in);
    end
    got_q.push_back(b);
  end
endmodule : qsp_uart_partner

//--- qsp_top_tb.sv
// Self-checking bench of the queued serial port
`timescale 1ns/1ns
module qsp_top_tb;
  import qsp_pkg::*;
  localparam int TD = 1;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, txd, sck;
  logic [1:0]  rxd;
  logic        p_rx;
  logic [31:0] d;
  int          fails = 0, n_tests = 0, sck_n = 0;
  // Channel 1 loops back on itself, channel 0 faces the model
  assign rxd = {txd[1], p_rx};
  always #5 aclk = ~aclk;
  always @(posedge sck[1]) sck_n++;

  qsp_top #(.TICK_DIV(TD)) qsp_top_inst (.*);
  qsp_uart_partner qsp_uart_partner_inst (.clk(aclk), .line_in(txd[0]), .line_out(p_rx));

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [7:0] ad(input int c, input logic [2:0] i);
    return {2'b00, c[0], i, 2'b00};
  endfunction : ad

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp; s_axi_bready <= 1'b0; break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 1'b0; break;
      end
    end
  endtask : rd

  task automatic cfg(input logic [2:0] src, input logic chr, pe, od, input int ratio);
    wr(ad(0, QSP_IDX_MODE), {21'h0, src, 1'b0, chr, pe, od, 4'h0});
    qsp_uart_partner_inst.bit_clks = ratio * TD;
    qsp_uart_partner_inst.nbits = chr ? 7 : 8;
    qsp_uart_partner_inst.par_en = pe;
    qsp_uart_partner_inst.odd = od;
    qsp_uart_partner_inst.got_q.delete();
    qsp_uart_partner_inst.par_q.delete();
  endtask : cfg

  task automatic wait_got(input int n);
    for (int k = 0; k < 30000 && qsp_uart_partner_inst.got_q.size() < n; k++) @(posedge aclk);
  endtask : wait_got

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_regs;
    rd(ad(0, QSP_IDX_MODE)); chk("mode reset", 32'h0, d);
    wr(ad(0, QSP_IDX_MODE), 32'h0000FFFF);
    rd(ad(0, QSP_IDX_MODE)); chk("mode top", 32'h07FF, d);
    rd(ad(1, QSP_IDX_MODE)); chk("ch1 mode", 32'h0, d);
    rd(8'h40); chk("unmapped resp", QSP_RESP_DECERR, rsp);
  endtask : t_regs

  task automatic t_ratios;
    int rt[5] = '{16, 5, 11, 13, 29};
    for (int i = 0; i < 5; i++) begin
      cfg(i[2:0], 1'b0, 1'b0, 1'b0, rt[i]);
      wr(ad(0, QSP_IDX_TXQ), 8'hC1 ^ i[7:0]);
      wait_got(1);
      chk("tx char", 8'hC1 ^ i[7:0], qsp_uart_partner_inst.got_q[0]);
      qsp_uart_partner_inst.send(8'h5A + i[7:0]);
      repeat (4) @(posedge aclk);
      rd(ad(0, QSP_IDX_RXQ)); chk("rx char", 8'h5A + i[7:0], d);
    end
  endtask : t_ratios

  task automatic t_format;
    for (int o = 0; o < 2; o++) begin
      cfg(3'h1, 1'b1, 1'b1, o[0], 5);
      wr(ad(0, QSP_IDX_TXQ), 8'hA5);
      wait_got(1);
      chk("seven bit", 8'h25, qsp_uart_partner_inst.got_q[0]);
      chk("parity", o[0] ^ 1'b1, qsp_uart_partner_inst.par_q[0]);
      qsp_uart_partner_inst.send(8'hDA);
      repeat (4) @(posedge aclk);
      rd(ad(0, QSP_IDX_RXQ)); chk("rx seven", 8'h5A, d);
      rd(ad(0, QSP_IDX_STAT)); chk("parity flag", 32'h0, d & 32'h10000);
    end
  endtask : t_format

  task automatic t_txfull;
    // Slow frames let the queue fill
    cfg(3'h4, 1'b0, 1'b0, 1'b0, 29);
    for (int i = 0; i < 65; i++) wr(ad(0, QSP_IDX_TXQ), i);
    wr(ad(0, QSP_IDX_TXQ), 8'hEE);
    rd(ad(0, QSP_IDX_TXQ)); chk("tx read", 32'h0, d);
    wait_got(65);
    repeat (400) @(posedge aclk);
    chk("tx count", 65, qsp_uart_partner_inst.got_q.size());
    for (int i = 0; i < 65; i++) chk("tx seq", i, qsp_uart_partner_inst.got_q[i]);
  endtask : t_txfull

  task automatic t_rxfull;
    cfg(3'h1, 1'b0, 1'b0, 1'b0, 5);
    for (int i = 0; i < 66; i++) qsp_uart_partner_inst.send(i[7:0]);
    repeat (4) @(posedge aclk);
    rd(ad(0, QSP_IDX_STAT)); chk("rx full", 64, d & 32'h7F);
    for (int i = 0; i < 64; i++) begin
      rd(ad(0, QSP_IDX_RXQ)); chk("rx seq", i, d);
    end
    rd(ad(0, QSP_IDX_RXQ));
    rd(ad(0, QSP_IDX_STAT)); chk("empty read", 0, d & 32'h7F);
    wr(ad(0, QSP_IDX_RXQ), 8'h77); chk("rx write resp", QSP_RESP_OKAY, rsp);
    rd(ad(0, QSP_IDX_STAT)); chk("rx write", 0, d & 32'h7F);
  endtask : t_rxfull

  task automatic t_sync;
    logic [7:0] b;
    wr(ad(1, QSP_IDX_MODE), 32'h00E0);
    sck_n = 0;
    wr(ad(1, QSP_IDX_TXQ), 8'hA5);
    for (int i = 0; i < 8; i++) begin
      @(posedge sck[1]);
      b[i] = txd[1];
    end
    repeat (40) @(posedge aclk);
    chk("sync data", 8'hA5, b);
    chk("sync clocks", 8, sck_n);
    rd(ad(1, QSP_IDX_RXQ)); chk("sync loop", 8'hA5, d);
    rd(ad(0, QSP_IDX_STAT)); chk("ch0 apart", 0, d & 32'h7F);
  endtask : t_sync

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ratios();
    t_format();
    t_txfull();
    t_rxfull();
    t_sync();
    wrap_up();
  end
endmodule : qsp_top_tb

bind qsp_top qsp_top_props #(.NCH(NCH)) qsp_top_props_inst (.*);
